// *** verilog/uart_flags_pkg.sv ***
// Constants, register map and state encodings of the serial port.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
package uart_flags_pkg;

  // Byte addresses of the register words
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TXDATA_OFS = 8'h04;
  localparam logic [7:0] RXDATA_OFS = 8'h08;
  localparam logic [7:0] BAUD_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // Fields of serial_port_control_status
  localparam int MODE_BIT = 7;
  localparam int UNUSED_BIT = 6;
  localparam int MCE_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TB8_BIT = 3;
  localparam int RB8_BIT = 2;
  localparam int TI_BIT = 1;
  localparam int RI_BIT = 0;

  // Field of the transmit data word
  localparam int TX_BUSY_BIT = 8;

  // Interrupt status and mask layout
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int IRQ_W = 2;

  // Values after reset
  localparam logic [15:0] BAUD_DIV_RST = 16'h0364;
  localparam logic [7:0] TX_BYTE_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // Frame shape
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_NINTH = 3'b011,
    TX_STOP = 3'b100
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP = 3'b100
  } rx_state_t;

endpackage

// *** verilog/uart_link_if.sv ***
// Signals between the register block and the two serial engines.
// Assumes all parties run on one clock.
`timescale 1ns/1ps
`default_nettype none
interface uart_link_if;
  logic tx_start;
  logic [7:0] tx_byte;
  logic nine_bit;
  logic ninth_tx;
  logic [15:0] baud_div;
  logic tx_busy;
  logic tx_done;
  logic txd;
  logic rx_en;
  logic rxd;
  logic rx_done;
  logic [7:0] rx_byte;
  logic rx_ninth;
  logic rx_stop;

  modport ctl (
    output tx_start, tx_byte, nine_bit, ninth_tx, baud_div, rx_en, rxd,
    input tx_busy, tx_done, txd, rx_done, rx_byte, rx_ninth, rx_stop
  );
  modport tx (
    input tx_start, tx_byte, nine_bit, ninth_tx, baud_div,
    output tx_busy, tx_done, txd
  );
  modport rx (
    input rx_en, rxd, nine_bit, baud_div,
    output rx_done, rx_byte, rx_ninth, rx_stop
  );
endinterface
`default_nettype wire

// *** verilog/uart_tx_engine.sv ***
// Serial transmitter: start, 8 data bits LSB first, optional ninth, stop.
// Assumes tx_start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
`default_nettype none
module uart_tx_engine (
  input wire logic core_clk,
  input wire logic rst,
  uart_link_if.tx lnk
);
  uart_flags_pkg::tx_state_t state_ff, nxt_state;
  logic [15:0] baud_ff, nxt_baud;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] shift_ff, nxt_shift;
  logic txd_ff, nxt_txd;
  logic done_ff, nxt_done;
  logic tick;

  always_comb
  begin
    tick = (baud_ff == 16'h0000);
    nxt_state = state_ff;
    nxt_baud = tick ? 16'(lnk.baud_div - 16'h0001) : 16'(baud_ff - 16'h0001);
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_txd = txd_ff;
    nxt_done = 1'b0;
    case (state_ff)
      uart_flags_pkg::TX_IDLE:
      begin
        nxt_txd = 1'b1;
        nxt_baud = 16'(lnk.baud_div - 16'h0001);
        if (lnk.tx_start)
        begin
          nxt_shift = lnk.tx_byte;
          nxt_txd = 1'b0;
          nxt_state = uart_flags_pkg::TX_START;
        end
      end
      uart_flags_pkg::TX_START:
        if (tick)
        begin
          nxt_txd = shift_ff[0];
          nxt_bit = 4'h0;
          nxt_state = uart_flags_pkg::TX_DATA;
        end
      uart_flags_pkg::TX_DATA:
        if (tick && bit_ff == uart_flags_pkg::LAST_DATA_BIT)
        begin
          if (lnk.nine_bit)
          begin
            nxt_txd = lnk.ninth_tx;
            nxt_state = uart_flags_pkg::TX_NINTH;
          end
          else
          begin
            nxt_txd = 1'b1;
            nxt_done = 1'b1;
            nxt_state = uart_flags_pkg::TX_STOP;
          end
        end
        else if (tick)
        begin
          nxt_shift = {1'b0, shift_ff[7:1]};
          nxt_txd = shift_ff[1];
          nxt_bit = 4'(bit_ff + 4'h1);
        end
      uart_flags_pkg::TX_NINTH:
        if (tick)
        begin
          nxt_txd = 1'b1;
          nxt_done = 1'b1;
          nxt_state = uart_flags_pkg::TX_STOP;
        end
      uart_flags_pkg::TX_STOP:
        if (tick)
          nxt_state = uart_flags_pkg::TX_IDLE;
      default:
        nxt_state = uart_flags_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= uart_flags_pkg::TX_IDLE;
      baud_ff <= 16'h0000;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      txd_ff <= 1'b1;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      baud_ff <= nxt_baud;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      txd_ff <= nxt_txd;
      done_ff <= nxt_done;
    end
  end

  assign lnk.tx_busy = (state_ff != uart_flags_pkg::TX_IDLE);
  assign lnk.tx_done = done_ff;
  assign lnk.txd = txd_ff;
endmodule // uart_tx_engine
`default_nettype wire

// *** verilog/uart_rx_engine.sv ***
// Serial receiver sampling each bit in its middle.
// Assumes rxd is already synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_engine (
  input wire logic core_clk,
  input wire logic rst,
  uart_link_if.rx lnk
);
  uart_flags_pkg::rx_state_t state_ff, nxt_state;
  logic [15:0] baud_ff, nxt_baud;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] shift_ff, nxt_shift;
  logic ninth_ff, nxt_ninth;
  logic stop_ff, nxt_stop;
  logic done_ff, nxt_done;
  logic tick;

  always_comb
  begin
    tick = (baud_ff == 16'h0000);
    nxt_state = state_ff;
    nxt_baud = tick ? 16'(lnk.baud_div - 16'h0001) : 16'(baud_ff - 16'h0001);
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_ninth = ninth_ff;
    nxt_stop = stop_ff;
    nxt_done = 1'b0;
    case (state_ff)
      uart_flags_pkg::RX_IDLE:
      begin
        nxt_baud = {1'b0, lnk.baud_div[15:1]};
        if (lnk.rx_en && !lnk.rxd)
          nxt_state = uart_flags_pkg::RX_START;
      end
      uart_flags_pkg::RX_START:
        if (tick)
        begin
          // A start bit gone high by mid-bit was a glitch
          nxt_bit = 4'h0;
          nxt_state = lnk.rxd ? uart_flags_pkg::RX_IDLE
                              : uart_flags_pkg::RX_DATA;
        end
      uart_flags_pkg::RX_DATA:
        if (tick)
        begin
          nxt_shift = {lnk.rxd, shift_ff[7:1]};
          nxt_bit = 4'(bit_ff + 4'h1);
          if (bit_ff == uart_flags_pkg::LAST_DATA_BIT)
            nxt_state = lnk.nine_bit ? uart_flags_pkg::RX_NINTH
                                     : uart_flags_pkg::RX_STOP;
        end
      uart_flags_pkg::RX_NINTH:
        if (tick)
        begin
          nxt_ninth = lnk.rxd;
          nxt_state = uart_flags_pkg::RX_STOP;
        end
      uart_flags_pkg::RX_STOP:
        if (tick)
        begin
          nxt_stop = lnk.rxd;
          nxt_done = 1'b1;
          nxt_state = uart_flags_pkg::RX_IDLE;
        end
      default:
        nxt_state = uart_flags_pkg::RX_IDLE;
    endcase
    // Dropping the enable abandons a frame in flight
    if (!lnk.rx_en)
    begin
      nxt_state = uart_flags_pkg::RX_IDLE;
      nxt_done = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= uart_flags_pkg::RX_IDLE;
      baud_ff <= 16'h0000;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      ninth_ff <= 1'b0;
      stop_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      baud_ff <= nxt_baud;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      ninth_ff <= nxt_ninth;
      stop_ff <= nxt_stop;
      done_ff <= nxt_done;
    end
  end

  assign lnk.rx_done = done_ff;
  assign lnk.rx_byte = shift_ff;
  assign lnk.rx_ninth = ninth_ff;
  assign lnk.rx_stop = stop_ff;
endmodule // uart_rx_engine
`default_nettype wire

// *** verilog/uart_serial_control_flags.sv ***
// Serial port with control/status flags, behind a classic Wishbone slave.
// Assumes rxd synchronous to core_clk and a single-cycle Wishbone master.
//
// Contract
// - A mode bit selects an 8-data-bit or a 9-data-bit frame at a set rate.
// - Bit 6 of the control register always reads one and ignores writes.
// - In 8-bit mode with the check enabled, a zero stop bit sets no flag.
// - In 9-bit mode with the check enabled, a zero ninth bit sets no flag.
// - Frames are received only while the receive enable is one.
// - In 9-bit mode the ninth transmit field is sent as the ninth bit.
// - In 8-bit mode the ninth receive field takes the stop bit level.
// - In 9-bit mode the ninth receive field takes the ninth data bit.
// - Transmit complete sets at the end of the data bits of a frame.
// - Receive complete sets when the stop bit is sampled, if qualified.
// - A completion event sets a sticky status bit that raises the interrupt when enabled.
`timescale 1ns/1ps
`default_nettype none
module uart_serial_control_flags (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  uart_link_if lnk ();

  // Control register fields
  logic mode_ff, nxt_mode;
  logic mce_ff, nxt_mce;
  logic ren_ff, nxt_ren;
  logic tb8_ff, nxt_tb8;
  logic rb8_ff, nxt_rb8;
  logic ti_ff, nxt_ti;
  logic ri_ff, nxt_ri;

  // Data path and rate
  logic [7:0] tx_byte_ff, nxt_tx_byte;
  logic tx_start_ff, nxt_tx_start;
  logic [7:0] rx_data_ff, nxt_rx_data;
  logic [15:0] baud_ff, nxt_baud;

  // Interrupt status, mask and line
  logic [uart_flags_pkg::IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [uart_flags_pkg::IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic [uart_flags_pkg::IRQ_W-1:0] irq_event;
  logic [uart_flags_pkg::IRQ_W-1:0] irq_clr;
  logic irq_ff, nxt_irq;

  // Bus
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic req;
  logic wr;
  logic rx_ok;
  logic ri_set;
  logic ti_set;
  logic [7:0] ctrl_rd;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic wr_lane(input logic w, input logic [7:0] adr,
                                   input logic [7:0] ofs, input logic sel);
    wr_lane = w && hit(adr, ofs) && sel;
  endfunction

  assign lnk.tx_start = tx_start_ff;
  assign lnk.tx_byte = tx_byte_ff;
  assign lnk.nine_bit = mode_ff;
  assign lnk.ninth_tx = tb8_ff;
  assign lnk.baud_div = baud_ff;
  assign lnk.rx_en = ren_ff;
  assign lnk.rxd = rxd;

  uart_tx_engine u_tx (
    .core_clk(core_clk),
    .rst(rst),
    .lnk(lnk.tx)
  );

  uart_rx_engine u_rx (
    .core_clk(core_clk),
    .rst(rst),
    .lnk(lnk.rx)
  );

  // One access per request; the write lands on the edge that raises ack
  always_comb
  begin
    req = wb_cyc_i && wb_stb_i && !ack_ff;
    wr = req && wb_we_i;
    nxt_ack = req;
  end

  // Completion qualification
  always_comb
  begin
    if (mode_ff)
      rx_ok = !mce_ff || lnk.rx_ninth;
    else
      rx_ok = !mce_ff || lnk.rx_stop;
    ri_set = lnk.rx_done && rx_ok;
    ti_set = lnk.tx_done;
  end

  // Control register
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_mce = mce_ff;
    nxt_ren = ren_ff;
    nxt_tb8 = tb8_ff;
    nxt_rb8 = rb8_ff;
    nxt_ti = ti_ff;
    nxt_ri = ri_ff;
    nxt_rx_data = rx_data_ff;
    if (wr_lane(wr, wb_adr_i, uart_flags_pkg::CTRL_OFS, wb_sel_i[0]))
    begin
      // Bit 6 has no storage, so a write to it is lost
      nxt_mode = wb_dat_i[uart_flags_pkg::MODE_BIT];
      nxt_mce = wb_dat_i[uart_flags_pkg::MCE_BIT];
      nxt_ren = wb_dat_i[uart_flags_pkg::REN_BIT];
      nxt_tb8 = wb_dat_i[uart_flags_pkg::TB8_BIT];
      nxt_rb8 = wb_dat_i[uart_flags_pkg::RB8_BIT];
      nxt_ti = wb_dat_i[uart_flags_pkg::TI_BIT];
      nxt_ri = wb_dat_i[uart_flags_pkg::RI_BIT];
    end
    if (ri_set)
    begin
      nxt_ri = 1'b1;
      nxt_rb8 = mode_ff ? lnk.rx_ninth : lnk.rx_stop;
      nxt_rx_data = lnk.rx_byte;
    end
    if (ti_set)
      nxt_ti = 1'b1;
  end

  // Transmit launch, rate divisor
  always_comb
  begin
    nxt_tx_byte = tx_byte_ff;
    nxt_tx_start = 1'b0;
    nxt_baud = baud_ff;
    // Writes while a frame is on the line are dropped, not queued
    if (wr_lane(wr, wb_adr_i, uart_flags_pkg::TXDATA_OFS, wb_sel_i[0]) &&
        !lnk.tx_busy && !tx_start_ff)
    begin
      nxt_tx_byte = wb_dat_i[7:0];
      nxt_tx_start = 1'b1;
    end
    if (wr_lane(wr, wb_adr_i, uart_flags_pkg::BAUD_OFS, wb_sel_i[0]))
      nxt_baud[7:0] = wb_dat_i[7:0];
    if (wr_lane(wr, wb_adr_i, uart_flags_pkg::BAUD_OFS, wb_sel_i[1]))
      nxt_baud[15:8] = wb_dat_i[15:8];
  end

  // Sticky interrupt status, write one to clear, event wins
  assign irq_event[uart_flags_pkg::IRQ_RX_BIT] = ri_set;
  assign irq_event[uart_flags_pkg::IRQ_TX_BIT] = ti_set;

  genvar gi;
  generate
    for (gi = 0; gi < uart_flags_pkg::IRQ_W; gi = gi + 1)
    begin : g_irq
      assign irq_clr[gi] = wr_lane(wr, wb_adr_i, uart_flags_pkg::IRQ_STAT_OFS,
                                   wb_sel_i[0]) && wb_dat_i[gi];
      assign nxt_irq_stat[gi] = irq_event[gi] ||
                                (irq_stat_ff[gi] && !irq_clr[gi]);
    end
  endgenerate

  always_comb
  begin
    nxt_irq_mask = irq_mask_ff;
    if (wr_lane(wr, wb_adr_i, uart_flags_pkg::IRQ_MASK_OFS, wb_sel_i[0]))
      nxt_irq_mask = wb_dat_i[uart_flags_pkg::IRQ_W-1:0];
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  // Read data
  always_comb
  begin
    ctrl_rd = 8'h00;
    ctrl_rd[uart_flags_pkg::MODE_BIT] = mode_ff;
    ctrl_rd[uart_flags_pkg::UNUSED_BIT] = 1'b1;
    ctrl_rd[uart_flags_pkg::MCE_BIT] = mce_ff;
    ctrl_rd[uart_flags_pkg::REN_BIT] = ren_ff;
    ctrl_rd[uart_flags_pkg::TB8_BIT] = tb8_ff;
    ctrl_rd[uart_flags_pkg::RB8_BIT] = rb8_ff;
    ctrl_rd[uart_flags_pkg::TI_BIT] = ti_ff;
    ctrl_rd[uart_flags_pkg::RI_BIT] = ri_ff;
    nxt_dat = dat_ff;
    if (req && !wb_we_i)
    begin
      if (hit(wb_adr_i, uart_flags_pkg::CTRL_OFS))
        nxt_dat = {24'h00_0000, ctrl_rd};
      else if (hit(wb_adr_i, uart_flags_pkg::TXDATA_OFS))
      begin
        nxt_dat = {24'h00_0000, tx_byte_ff};
        nxt_dat[uart_flags_pkg::TX_BUSY_BIT] = lnk.tx_busy || tx_start_ff;
      end
      else if (hit(wb_adr_i, uart_flags_pkg::RXDATA_OFS))
        nxt_dat = {24'h00_0000, rx_data_ff};
      else if (hit(wb_adr_i, uart_flags_pkg::BAUD_OFS))
        nxt_dat = {16'h0000, baud_ff};
      else if (hit(wb_adr_i, uart_flags_pkg::IRQ_STAT_OFS))
        nxt_dat = {30'h0000_0000, irq_stat_ff};
      else if (hit(wb_adr_i, uart_flags_pkg::IRQ_MASK_OFS))
        nxt_dat = {30'h0000_0000, irq_mask_ff};
      else
        nxt_dat = 32'h0000_0000;
    end
  end

  // Control fields
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_ff <= 1'b0;
      mce_ff <= 1'b0;
      ren_ff <= 1'b0;
      tb8_ff <= 1'b0;
      rb8_ff <= 1'b0;
      ti_ff <= 1'b0;
      ri_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      mce_ff <= nxt_mce;
      ren_ff <= nxt_ren;
      tb8_ff <= nxt_tb8;
      rb8_ff <= nxt_rb8;
      ti_ff <= nxt_ti;
      ri_ff <= nxt_ri;
    end
  end

  // Transmit launch, received byte, rate
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_byte_ff <= uart_flags_pkg::TX_BYTE_RST;
      tx_start_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      baud_ff <= uart_flags_pkg::BAUD_DIV_RST;
    end
    else
    begin
      tx_byte_ff <= nxt_tx_byte;
      tx_start_ff <= nxt_tx_start;
      rx_data_ff <= nxt_rx_data;
      baud_ff <= nxt_baud;
    end
  end

  // Interrupt status, mask and line
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_stat_ff <= uart_flags_pkg::IRQ_RST;
      irq_mask_ff <= uart_flags_pkg::IRQ_RST;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq;
    end
  end

  // Bus answer
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign txd = lnk.txd;
  assign irq = irq_ff;
endmodule // uart_serial_control_flags
`default_nettype wire

// *** sim/uart_flags_sva.sv ***
// Port checker of the serial port: bus handshake, reads, line and irq.
// Assumes the bench programs a divisor of 8 core_clk cycles per bit.
`timescale 1ns/1ps
`default_nettype none
module uart_flags_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq
);
  logic rd_req;
  logic wr_ack;

  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign wr_ack = wb_ack_o && wb_we_i;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered after one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data changed without ack");
  bit6_read_a: assert property (rd_req && wb_adr_i == uart_flags_pkg::CTRL_OFS
    |=> wb_dat_o[uart_flags_pkg::UNUSED_BIT])
    else $error("unused control bit read zero");
  unmapped_zero_a: assert property (rd_req && wb_adr_i == 8'h20
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  start_len_a: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit shorter than one bit time");
  irq_clear_a: assert property ($fell(irq) |-> wr_ack)
    else $error("irq dropped without a register write");

  cover property ($rose(irq));
  cover property ($fell(txd));
  cover property (rd_req && wb_adr_i == uart_flags_pkg::RXDATA_OFS);
endmodule // uart_flags_sva
`default_nettype wire

// *** sim/uart_peer.sv ***
// Remote serial peer: drives frames onto rxd, captures frames from txd.
// Assumes a bit time of BIT core_clk cycles, equal to the programmed divisor.
`timescale 1ns/1ps
`default_nettype none
module uart_peer #(
  parameter int BIT = 8
) (
  input wire logic core_clk,
  input wire logic txd,
  input wire logic nine,
  output logic rxd
);
  logic [7:0] got_byte;
  logic got_ninth;
  int got_cnt;

  initial
  begin
    rxd = 1'h1;
    got_cnt = 0;
  end

  // Stop level is free so the bench can send a broken frame
  task automatic send(input logic [7:0] b, input logic n9, input logic stp);
    @(posedge core_clk);
    rxd <= 1'h0;
    repeat (BIT) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      rxd <= b[i];
      repeat (BIT) @(posedge core_clk);
    end
    if (nine)
    begin
      rxd <= n9;
      repeat (BIT) @(posedge core_clk);
    end
    rxd <= stp;
    repeat (BIT) @(posedge core_clk);
    rxd <= 1'h1;
    repeat (BIT) @(posedge core_clk);
  endtask

  // Mid-bit sampling of the device's frames
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge core_clk);
      got_byte[i] = txd;
    end
    if (nine)
    begin
      repeat (BIT) @(posedge core_clk);
      got_ninth = txd;
    end
    repeat (BIT) @(posedge core_clk);
    got_cnt++;
  end
endmodule // uart_peer
`default_nettype wire

// *** sim/tb_top.sv ***
// Bench of the serial port: Wishbone tasks, peer model and scenario list.
// Assumes the checker and peer files are compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Must match the divisor written below
  localparam int DIV = 8;
  typedef struct packed {
    logic [7:0] c;
    logic [7:0] d;
    logic n9;
    logic stp;
    logic ri;
    logic rb8;
  } rx_case_t;
  logic core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic rxd, txd, irq, nine;
  logic [1:0] txd_hist;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  rx_case_t rx_tab [7];
  int fail_count, n_tests;

  uart_serial_control_flags u_uart_serial_control_flags (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rxd(rxd), .txd(txd), .irq(irq)
  );
  uart_peer #(.BIT(DIV)) u_uart_peer (
    .core_clk(core_clk), .txd(txd), .nine(nine), .rxd(rxd)
  );

  initial
  begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tmo(input logic ok);
    if (!ok)
    begin
      fail_count++;
      $display("CHECK FAILED wait limit expected done seen hang");
      stop_test();
    end
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] got);
    n_tests++;
    if (got !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask

  // Request held until ack is sampled high, then released
  task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
    tmo(wb_ack_o === 1'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string what);
    bus(a, 1'h0, 32'h0000_0000);
    chk(what, e, q & m);
  endtask

  task automatic tx_case(input logic [7:0] c, input logic [7:0] b,
                         input logic n9, input logic edge_chk);
    int n;
    int c0;
    bus(uart_flags_pkg::IRQ_STAT_OFS, 1'h1, 32'h0000_0003);
    bus(uart_flags_pkg::CTRL_OFS, 1'h1, {24'h0, c});
    nine <= c[7];
    c0 = u_uart_peer.got_cnt;
    bus(uart_flags_pkg::TXDATA_OFS, 1'h1, {24'h0, b});
    n = 0;
    while (irq !== 1'h1 && n < 400)
    begin
      txd_hist = {txd_hist[0], txd};
      @(posedge core_clk);
      #1;
      n++;
    end
    tmo(n < 400);
    // Last bit low, then stop high; irq follows one cycle into the stop
    if (edge_chk)
      chk("stop start edge", 32'h0000_0003, {29'h0, txd_hist, txd});
    n = 0;
    while (u_uart_peer.got_cnt == c0 && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    tmo(n < 200);
    chk("peer byte", {24'h0, b}, {24'h0, u_uart_peer.got_byte});
    if (c[7])
      chk("peer ninth", {31'h0, n9}, {31'h0, u_uart_peer.got_ninth});
    repeat (50) @(posedge core_clk);
    rd(uart_flags_pkg::CTRL_OFS, 32'h0000_0002, 32'h0000_0002, "tx flag");
    rd(uart_flags_pkg::IRQ_STAT_OFS, 32'h0000_0003, 32'h0000_0002, "tx irq");
  endtask

  initial
  begin
    fail_count = 0;
    n_tests = 0;
    rst = 1'h1;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    nine = 1'h0;
    rx_tab = '{
      '{8'h10, 8'h3C, 1'h0, 1'h1, 1'h1, 1'h1},
      '{8'h10, 8'hC5, 1'h0, 1'h0, 1'h1, 1'h0},
      '{8'h30, 8'h5A, 1'h0, 1'h0, 1'h0, 1'h0},
      '{8'h00, 8'h69, 1'h0, 1'h1, 1'h0, 1'h0},
      '{8'hB0, 8'h96, 1'h0, 1'h1, 1'h0, 1'h0},
      '{8'hB0, 8'hE1, 1'h1, 1'h1, 1'h1, 1'h1},
      '{8'h90, 8'h0F, 1'h0, 1'h1, 1'h1, 1'h0}};
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    rd(uart_flags_pkg::CTRL_OFS, 32'h0000_00FF, 32'h0000_0040, "ctrl rst");
    rd(uart_flags_pkg::BAUD_OFS, 32'h0000_FFFF, 32'h0000_0364, "div rst");
    rd(uart_flags_pkg::IRQ_MASK_OFS, 32'h0000_0003, 32'h0000_0000, "mask rst");
    rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    bus(uart_flags_pkg::CTRL_OFS, 1'h1, 32'h0000_00BF);
    rd(uart_flags_pkg::CTRL_OFS, 32'h0000_00FF, 32'h0000_00FF, "ctrl all");
    bus(uart_flags_pkg::CTRL_OFS, 1'h1, 32'h0000_0000);
    bus(uart_flags_pkg::BAUD_OFS, 1'h1, 32'h0000_0008);
    bus(uart_flags_pkg::IRQ_MASK_OFS, 1'h1, 32'h0000_0003);
    $display("test registers done");
    tx_case(8'h08, 8'h25, 1'h0, 1'h1);
    tx_case(8'h80, 8'h4A, 1'h0, 1'h1);
    tx_case(8'h88, 8'hC3, 1'h1, 1'h0);
    $display("test transmit done");
    for (int i = 0; i < 7; i++)
    begin
      bus(uart_flags_pkg::IRQ_STAT_OFS, 1'h1, 32'h0000_0003);
      bus(uart_flags_pkg::CTRL_OFS, 1'h1, {24'h0, rx_tab[i].c});
      nine <= rx_tab[i].c[7];
      u_uart_peer.send(rx_tab[i].d, rx_tab[i].n9, rx_tab[i].stp);
      repeat (3 * DIV) @(posedge core_clk);
      rd(uart_flags_pkg::CTRL_OFS, 32'h0000_0005,
         {29'h0, rx_tab[i].rb8, 1'h0, rx_tab[i].ri}, "rx flags");
      chk("rx irq", {31'h0, rx_tab[i].ri}, {31'h0, irq});
      if (rx_tab[i].ri)
        rd(uart_flags_pkg::RXDATA_OFS, 32'h0000_00FF,
           {24'h0, rx_tab[i].d}, "rx byte");
    end
    $display("test receive done");
    bus(uart_flags_pkg::IRQ_MASK_OFS, 1'h1, 32'h0000_0002);
    repeat (3) @(posedge core_clk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    bus(uart_flags_pkg::IRQ_MASK_OFS, 1'h1, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
    bus(uart_flags_pkg::IRQ_STAT_OFS, 1'h1, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    rd(uart_flags_pkg::CTRL_OFS, 32'h0000_0001, 32'h0000_0001, "ri kept");
    $display("test interrupt done");
    stop_test();
  end
endmodule // tb_top

bind uart_serial_control_flags uart_flags_sva u_uart_flags_sva (
  .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rxd(rxd), .txd(txd), .irq(irq)
);
`default_nettype wire
